//--- irq_sense_defs.vh
// Constants for the external and pin-change interrupt sensing block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
`ifndef IRQ_SENSE_DEFS_VH
`define IRQ_SENSE_DEFS_VH

// Register byte offsets. Printed offset is 0x35, not a multiple of four, so index times four.
`define MCU_CONTROL_IDX      8'h35
`define MCU_CONTROL_ADDR     12'h0D4
`define IRQ_CONTROL_ADDR     12'h000
`define IRQ_STATUS_ADDR      12'h004
`define ALT_CONTROL_ADDR     12'h008
`define FUSE_ADDR            12'h00C
`define PIN_STATE_ADDR       12'h010

// Field positions of mcu_control.
`define PUD_BIT              6
`define SE_BIT               5
`define SM_HI                4
`define SM_LO                3
`define ISC_HI               1
`define ISC_LO               0
`define MCU_CONTROL_WMASK    8'h7B
`define MCU_CONTROL_RESET    8'h00

// Sense encodings.
`define SENSE_LOW            2'b00
`define SENSE_ANY            2'b01
`define SENSE_FALL           2'b10
`define SENSE_RISE           2'b11

// Fields of irq_control: bit 0 ext enable, bit 1 pin change lo, bit 2 pin change hi.
`define EN_EXT_BIT           0
`define EN_PC_LO_BIT         1
`define EN_PC_HI_BIT         2
// Fields of irq_status: bit 0 ext flag, bit 1 pin change flag (write one to clear).
`define FLAG_EXT_BIT         0
`define FLAG_PC_BIT          1

// Fields of alt_control.
`define ALT_REF_SEL_BIT      0
`define ALT_CMP_DIS_BIT      1
`define ALT_WM_LO_BIT        2
`define ALT_WM_HI_BIT        3
`define ALT_COMA_LO_BIT      4
`define ALT_COMA_HI_BIT      5
`define ALT_PWMA_BIT         6
`define ALT_COMB_LO_BIT      7
`define ALT_COMB_HI_BIT      8
`define ALT_PWMB_BIT         9
`define ALT_T0CS1_BIT        10
`define ALT_T0CS2_BIT        11
`define ALT_CONTROL_WIDTH    12
`define ALT_CONTROL_RESET    12'h000

// Fuse register: bits 4..0 clock select, bit 5 pll clock, bit 6 reset pin disable.
`define FUSE_WIDTH           7
`define FUSE_RESET           7'h7F
`define FUSE_RSTDIS_BIT      6
`define FUSE_CLK_HI          5
`define FUSE_CLK_LO          0
`define CLK_CRYSTAL_IN_ONLY       5'h10
`define CLK_CRYSTAL_IN_MIN        5'h15
`define CLK_CRYSTAL_OUT_MIN        5'h19

// External interrupt pin is port B pin 6 in the 16-bit pin vector {pa, pb}.
`define EXT_PIN_IDX          6
`define AXI_OKAY             2'b00
`define AXI_SLVERR           2'b10

`endif

//--- ext_pin_change_irq.v
// External interrupt and pin-change interrupt sensing with mcu_control register.
// Assumes pins are asynchronous to aclk; CPU acknowledges by one-cycle pulses.
//
// Functional notes
// - External request works with pin as output.
// - External pin sensed on four selectable conditions.
// - Sense codes low, change, falling, rising.
// - Low level keeps requesting while pin low.
// - Pin change on port B, PA3, PA6, PA7.
// - High enable gates upper group, low lower.
// - Clear pin change enable keeps pin change flag from setting; the ext flag sets regardless of its enable.
// - Alternate function pins excluded from pin change.
// - Reference, comparator, compare, crystal, timer, reset mask.
// - PB0/PB2 masked by serial modes or compare.
// - Masking conditions combine by logical OR.
// - PB0 suppressed by serial modes or compare.
// - Pin change works with pin as output.
// - One event may raise several requests.
// - Pull-up disable turns off every pull-up.
// - Sleep entered only while sleep enable set.
// - Sleep mode select picks one of four.
// - Reserved mcu_control bits read zero.
// - mcu_control resets to zero.
// - Pin change flag cleared by ack or write-one.
//
// The AXI4-Lite slave port is this design's own decision.
`include "irq_sense_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ext_pin_change_irq (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  port_a_pins,
    input  wire [7:0]  port_b_pins,
    input  wire        sleep_instr,
    input  wire        ext_irq_ack,
    input  wire        pin_change_ack,
    output reg         ext_irq_request,
    output reg         pin_change_request,
    output reg         pullups_disabled,
    output reg         sleep_entry,
    output reg  [1:0]  sleep_mode
);

    // ************************************************************
    // Registers and synchronisers
    // ************************************************************
    reg  [7:0]  mcu_control_reg;
    reg  [2:0]  irq_control_reg;
    reg         ext_flag_reg;
    reg         pc_flag_reg;
    reg  [11:0] alt_control_reg;
    reg  [6:0]  fuse_reg;
    reg  [15:0] sync1_reg;
    reg  [15:0] sync2_reg;
    reg  [15:0] prev_reg;
    reg  [11:0] aw_addr_reg;
    reg         aw_have_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_have_reg;

    function is_addr;
        input [11:0] a;
        input [11:0] r;
        begin
            is_addr = (a[11:2] == r[11:2]);
        end
    endfunction

    // two flip-flops then compare with previous sample.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            prev_reg  <= 16'h0000;
        end else begin
            sync1_reg <= {port_a_pins, port_b_pins};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // ************************************************************
    // Alternate function masking
    // ************************************************************
    wire [15:0] changed = sync2_reg ^ prev_reg;
    wire [1:0]  sense   = mcu_control_reg[`ISC_HI:`ISC_LO];
    // The crystal conditions treat the pll fuse and the four low clock select bits as one five-bit code.
    wire [4:0]  clk_sel = {fuse_reg[`FUSE_CLK_HI], fuse_reg[`FUSE_CLK_HI-2:`FUSE_CLK_LO]};
    wire [1:0]  wm      = {alt_control_reg[`ALT_WM_HI_BIT], alt_control_reg[`ALT_WM_LO_BIT]};
    wire [2:0]  coma    = {alt_control_reg[`ALT_COMA_HI_BIT], alt_control_reg[`ALT_COMA_LO_BIT],
                           alt_control_reg[`ALT_PWMA_BIT]};
    wire [2:0]  comb    = {alt_control_reg[`ALT_COMB_HI_BIT], alt_control_reg[`ALT_COMB_LO_BIT],
                           alt_control_reg[`ALT_PWMB_BIT]};
    wire        wire2   = wm[1];
    wire        wire3   = (wm == 2'b01);
    wire [15:0] alt_mask;
    // Each term is an independent alternate-function condition.
    assign alt_mask[0]  = wire2 | wire3 | (coma == 3'b011);
    assign alt_mask[1]  = wire3 | alt_control_reg[`ALT_COMA_HI_BIT] | alt_control_reg[`ALT_COMA_LO_BIT];
    assign alt_mask[2]  = wire2 | wire3 | (comb == 3'b011);
    assign alt_mask[3]  = alt_control_reg[`ALT_COMB_HI_BIT] | alt_control_reg[`ALT_COMB_LO_BIT];
    assign alt_mask[4]  = (clk_sel == `CLK_CRYSTAL_IN_ONLY) |
                          (clk_sel >= `CLK_CRYSTAL_IN_MIN);
    assign alt_mask[5]  = (clk_sel >= `CLK_CRYSTAL_OUT_MIN);
    assign alt_mask[6]  = (irq_control_reg[`EN_EXT_BIT] & (sense == `SENSE_LOW)) |
                          (alt_control_reg[`ALT_T0CS2_BIT] & alt_control_reg[`ALT_T0CS1_BIT]);
    assign alt_mask[7]  = fuse_reg[`FUSE_RSTDIS_BIT];
    assign alt_mask[10:8]  = 3'b000;
    assign alt_mask[11] = alt_control_reg[`ALT_REF_SEL_BIT];
    assign alt_mask[13:12] = 2'b00;
    assign alt_mask[14] = ~alt_control_reg[`ALT_CMP_DIS_BIT];
    assign alt_mask[15] = ~alt_control_reg[`ALT_CMP_DIS_BIT];

    // Group gates: lower enable covers PB3..0, upper covers PB7..4, PA3, PA6, PA7.
    wire [15:0] group_en = {{2{irq_control_reg[`EN_PC_HI_BIT]}}, 2'b00,
                            irq_control_reg[`EN_PC_HI_BIT], 3'b000,
                            {4{irq_control_reg[`EN_PC_HI_BIT]}},
                            {4{irq_control_reg[`EN_PC_LO_BIT]}}};
    // Pins are sampled regardless of direction, so driven outputs also count.
    wire pc_event = |(changed & group_en & ~alt_mask);

    // ************************************************************
    // External interrupt sense
    // ************************************************************
    reg ext_event;
    always @* begin
        ext_event = 1'b0;
        case (sense)
            `SENSE_LOW:  ext_event = ~sync2_reg[`EXT_PIN_IDX];
            `SENSE_ANY:  ext_event = changed[`EXT_PIN_IDX];
            `SENSE_FALL: ext_event = changed[`EXT_PIN_IDX] & ~sync2_reg[`EXT_PIN_IDX];
            `SENSE_RISE: ext_event = changed[`EXT_PIN_IDX] & sync2_reg[`EXT_PIN_IDX];
            default:     ext_event = 1'b0;
        endcase
    end
    wire ext_level = (sense == `SENSE_LOW);

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    // Decoded only at commit, when both halves of the write are held in the copies.
    wire wr_known = is_addr(aw_addr_reg, `MCU_CONTROL_ADDR) | is_addr(aw_addr_reg, `IRQ_CONTROL_ADDR) |
                    is_addr(aw_addr_reg, `IRQ_STATUS_ADDR) | is_addr(aw_addr_reg, `ALT_CONTROL_ADDR) |
                    is_addr(aw_addr_reg, `FUSE_ADDR);

    reg [31:0] rd_data;
    reg        rd_known;
    always @* begin
        rd_data  = 32'h0000_0000;
        rd_known = 1'b1;
        if (is_addr(s_axi_araddr, `MCU_CONTROL_ADDR))
            rd_data[7:0] = mcu_control_reg & `MCU_CONTROL_WMASK;
        else if (is_addr(s_axi_araddr, `IRQ_CONTROL_ADDR))
            rd_data[2:0] = irq_control_reg;
        else if (is_addr(s_axi_araddr, `IRQ_STATUS_ADDR))
            rd_data[1:0] = {pc_flag_reg, ext_flag_reg};
        else if (is_addr(s_axi_araddr, `ALT_CONTROL_ADDR))
            rd_data[11:0] = alt_control_reg;
        else if (is_addr(s_axi_araddr, `FUSE_ADDR))
            rd_data[6:0] = fuse_reg;
        else if (is_addr(s_axi_araddr, `PIN_STATE_ADDR))
            rd_data[15:0] = sync2_reg;
        else
            rd_known = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `AXI_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 12'h000;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            // Ready is asserted for one cycle when a valid appears, no copy is held and no write response is pending.
            s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_have_reg & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_have_reg & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_have_reg & w_have_reg & ~s_axi_bvalid) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Control registers, flags and outputs
    // ************************************************************
    wire commit = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire cm_mcu  = commit & w_strb_reg[0] & is_addr(aw_addr_reg, `MCU_CONTROL_ADDR);
    wire cm_ictl = commit & w_strb_reg[0] & is_addr(aw_addr_reg, `IRQ_CONTROL_ADDR);
    wire cm_stat = commit & w_strb_reg[0] & is_addr(aw_addr_reg, `IRQ_STATUS_ADDR);
    wire cm_alt  = commit & is_addr(aw_addr_reg, `ALT_CONTROL_ADDR);
    wire cm_fuse = commit & w_strb_reg[0] & is_addr(aw_addr_reg, `FUSE_ADDR);

    always @(posedge aclk) begin
        if (!aresetn) begin
            mcu_control_reg    <= `MCU_CONTROL_RESET;
            irq_control_reg    <= 3'b000;
            ext_flag_reg       <= 1'b0;
            pc_flag_reg        <= 1'b0;
            alt_control_reg    <= `ALT_CONTROL_RESET;
            fuse_reg           <= `FUSE_RESET;
            ext_irq_request    <= 1'b0;
            pin_change_request <= 1'b0;
            pullups_disabled   <= 1'b0;
            sleep_entry        <= 1'b0;
            sleep_mode         <= 2'b00;
        end else begin
            if (cm_mcu)
                mcu_control_reg <= w_data_reg[7:0] & `MCU_CONTROL_WMASK;
            if (cm_ictl)
                irq_control_reg <= w_data_reg[2:0];
            if (cm_alt)
                alt_control_reg <= w_data_reg[`ALT_CONTROL_WIDTH-1:0];
            if (cm_fuse)
                fuse_reg <= w_data_reg[`FUSE_WIDTH-1:0];
            // Set wins over ack and write-one clear so no event is lost in the clearing cycle.
            if (ext_level)
                ext_flag_reg <= 1'b0;
            else if (ext_event)
                ext_flag_reg <= 1'b1;
            else if (ext_irq_ack | (cm_stat & w_data_reg[`FLAG_EXT_BIT]))
                ext_flag_reg <= 1'b0;
            if (pc_event)
                pc_flag_reg <= 1'b1;
            else if (pin_change_ack | (cm_stat & w_data_reg[`FLAG_PC_BIT]))
                pc_flag_reg <= 1'b0;
            // Level mode requests directly from the pin for as long as it is low.
            ext_irq_request <= irq_control_reg[`EN_EXT_BIT] &
                               (ext_level ? ext_event : (ext_flag_reg | ext_event));
            pin_change_request <= pc_flag_reg | pc_event;
            pullups_disabled   <= mcu_control_reg[`PUD_BIT];
            sleep_entry        <= sleep_instr & mcu_control_reg[`SE_BIT];
            sleep_mode         <= mcu_control_reg[`SM_HI:`SM_LO];
        end
    end

endmodule // ext_pin_change_irq

`default_nettype wire

//--- irq_sense_sva.sv
// Concurrent checks on the ports of the interrupt sensing block.
// Assumes it is bound to ext_pin_change_irq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "irq_sense_defs.vh"
// ****************************************
// Checker
// ****************************************
module irq_sense_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  port_a_pins,
    input wire logic [7:0]  port_b_pins,
    input wire logic        sleep_instr,
    input wire logic        ext_irq_request,
    input wire logic        pin_change_request,
    input wire logic        pullups_disabled,
    input wire logic        sleep_entry,
    input wire logic [1:0]  sleep_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // A window of five samples covers two sync stages, the compare and the request register.
    sequence pin_moved;
        $past(port_a_pins, 2) != $past(port_a_pins, 7) || $past(port_b_pins, 2) != $past(port_b_pins, 7);
    endsequence
    reset_zero_a: assert property (disable iff (1'b0) !aresetn |=> !ext_irq_request &&
        !pin_change_request && !pullups_disabled && !sleep_entry && sleep_mode == 2'b00)
        else $error("outputs not cleared by reset");
    sleep_gate_a: assert property (sleep_entry |-> $past(sleep_instr))
        else $error("sleep entry without sleep instruction");
    copy_update_a: assert property (($changed(sleep_mode) || $changed(pullups_disabled))
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("control output moved without a write");
    bresp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp == `AXI_OKAY || s_axi_bresp == `AXI_SLVERR)
        else $error("illegal write response");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
    aw_take_a: assert property (s_axi_awvalid && !s_axi_awready && !s_axi_bvalid |-> ##[1:4] s_axi_awready)
        else $error("write address not taken");
    pc_cause_a: assert property ($rose(pin_change_request) |-> pin_moved)
        else $error("pin change request without pin activity");
    ext_cause_a: assert property ($rose(ext_irq_request) |-> !$past(port_b_pins[6], 2) ||
        $past(port_b_pins[6], 2) != $past(port_b_pins[6], 7)) else $error("external request without cause");
endmodule // irq_sense_sva

bind ext_pin_change_irq irq_sense_sva chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .sleep_instr(sleep_instr), .ext_irq_request(ext_irq_request),
    .pin_change_request(pin_change_request), .pullups_disabled(pullups_disabled),
    .sleep_entry(sleep_entry), .sleep_mode(sleep_mode));
`default_nettype wire

//--- cpu_pin_model.sv
// Far side model: port pin levels and the CPU strobes.
// Assumes the caller runs its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Pin and CPU model
// ****************************************
module cpu_pin_model (
    input  wire logic       aclk,
    output var  logic [7:0] port_a_pins,
    output var  logic [7:0] port_b_pins,
    output var  logic       sleep_instr,
    output var  logic       ext_irq_ack,
    output var  logic       pin_change_ack
);
    initial begin
        port_a_pins = 8'h00;
        port_b_pins = 8'h40;
        {sleep_instr, ext_irq_ack, pin_change_ack} = 3'b000;
    end
    // Levels change whether the pin is an input or driven by the port.
    task toggle(input int i);
        @(posedge aclk);
        if (i < 8) port_b_pins[i] <= !port_b_pins[i];
        else port_a_pins[i-8] <= !port_a_pins[i-8];
    endtask
    task pulse(input int k);
        @(posedge aclk);
        case (k)
            0: sleep_instr <= 1'b1;
            1: ext_irq_ack <= 1'b1;
            default: pin_change_ack <= 1'b1;
        endcase
        @(posedge aclk);
        {sleep_instr, ext_irq_ack, pin_change_ack} <= 3'b000;
    endtask
endmodule // cpu_pin_model
`default_nettype wire

//--- ext_and_pin_change_irq_sense_tb.sv
// Self-checking bench for the interrupt sensing block.
// Assumes the AXI slave answers within the cycle ceiling.
`timescale 1ns/1ps
`default_nettype none
`include "irq_sense_defs.vh"
// ****************************************
// Bench
// ****************************************
module ext_and_pin_change_irq_sense_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  rr = 2'b00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, ereq, preq, pullup_disable, slp, sli, eack, pack;
    wire [1:0]   bresp, rresp, smode;
    wire [31:0]  rdata;
    wire [7:0]   pa, pb;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    // Each entry: alternate controls, pin index, irq enables, expected request.
    localparam logic [19:0] pc_tab [14] = '{20'h0_0215, 20'h0_0218, 20'h0_0254, 20'h0_02B9, 20'h0_028C,
        20'h0_020D, 20'h0_080C, 20'h0_042C, 20'h0_500C, 20'h0_01BC, 20'h0_00EC, 20'h0_02ED, 20'h0_024C,
        20'h0_0C2C};

    ext_pin_change_irq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_pins(pa),
        .port_b_pins(pb), .sleep_instr(sli), .ext_irq_ack(eack), .pin_change_ack(pack),
        .ext_irq_request(ereq), .pin_change_request(preq), .pullups_disabled(pullup_disable),
        .sleep_entry(slp), .sleep_mode(smode));
    cpu_pin_model u (.aclk(aclk), .port_a_pins(pa), .port_b_pins(pb), .sleep_instr(sli),
        .ext_irq_ack(eack), .pin_change_ack(pack));

    always #20 aclk = ~aclk;

    task end_sim;
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wclk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hF, r);
    endtask
    task axi_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                rr = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(`MCU_CONTROL_ADDR, d);
        chk(d, 32'h0000_0000);
        chk(32'({ereq, preq, pullup_disable, slp, smode}), 32'h0000_0000);
        wr(`MCU_CONTROL_ADDR, 32'hFFFF_FFFF);
        axi_rd(`MCU_CONTROL_ADDR, d);
        chk(d, 32'h0000_007B);
        wclk(2);
        chk(32'(pullup_disable), 32'h0000_0001);
        u.pulse(0);
        #1 chk(32'(slp), 32'h0000_0001);
        wr(`MCU_CONTROL_ADDR, 32'h0000_0000);
        u.pulse(0);
        #1 chk(32'(slp), 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            wr(`MCU_CONTROL_ADDR, 32'(m) << 3);
            wclk(2);
            chk(32'(smode), 32'(m));
        end
        axi_wr(`MCU_CONTROL_ADDR, 32'h0000_0027, 4'h0, r);
        axi_rd(`MCU_CONTROL_ADDR, d);
        chk(d, 32'h0000_0018);
        chk(32'(rr), 32'(`AXI_OKAY));
        axi_rd(12'h100, d);
        chk(d, 32'h0000_0000);
        chk(32'(rr), 32'(`AXI_SLVERR));
        axi_wr(12'h100, 32'h0000_0001, 4'hF, r);
        chk(32'(r), 32'(`AXI_SLVERR));
    endtask
    task t_ext;
        for (int m = 0; m < 4; m++) begin
            wr(`IRQ_CONTROL_ADDR, 32'h0000_0000);
            wr(`MCU_CONTROL_ADDR, 32'(m));
            wr(`IRQ_STATUS_ADDR, 32'h0000_0003);
            wr(`IRQ_CONTROL_ADDR, 32'h0000_0001);
            wclk(2);
            chk(32'(ereq), 32'h0000_0000);
            u.toggle(6);
            wclk(6);
            chk(32'(ereq), 32'(m != 3));
            u.pulse(1);
            wr(`IRQ_STATUS_ADDR, 32'h0000_0001);
            wclk(2);
            chk(32'(ereq), 32'(m == 0));
            u.toggle(6);
            wclk(6);
            chk(32'(ereq), 32'(m == 1 || m == 3));
        end
        wr(`IRQ_CONTROL_ADDR, 32'h0000_0000);
    endtask
    task t_both;
        wr(`ALT_CONTROL_ADDR, 32'h0000_0002);
        wr(`MCU_CONTROL_ADDR, 32'h0000_0001);
        wr(`IRQ_STATUS_ADDR, 32'h0000_0003);
        wr(`IRQ_CONTROL_ADDR, 32'h0000_0005);
        u.toggle(6);
        wclk(6);
        chk(32'({ereq, preq}), 32'h0000_0003);
        wr(`IRQ_CONTROL_ADDR, 32'h0000_0000);
    endtask
    task t_pc;
        logic [31:0] d;
        logic [19:0] v;
        for (int i = 0; i < 14; i++) begin
            v = pc_tab[i];
            wr(`ALT_CONTROL_ADDR, 32'(v[19:8]));
            wr(`IRQ_CONTROL_ADDR, 32'(v[3:1]));
            wr(`IRQ_STATUS_ADDR, 32'h0000_0003);
            u.toggle(int'(v[7:4]));
            wclk(6);
            chk(32'(preq), 32'(v[0]));
            axi_rd(`IRQ_STATUS_ADDR, d);
            chk(32'(d[1]), 32'(v[0]));
            if (v[0]) begin
                u.pulse(2);
                wclk(2);
                chk(32'(preq), 32'h0000_0000);
            end
        end
    endtask

    // The ceiling is over twenty times the fewer than one thousand cycles the scenarios need.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_ext;
        t_both;
        t_pc;
        end_sim;
    end
endmodule // ext_and_pin_change_irq_sense_tb
`default_nettype wire
